// ===== pkg/seq_jump_pkg.sv
// Purpose: constants for the conditional jump next-address block
// Assumes: 7-bit instruction word, 16-bit address and data
// Notes: opcode codes are the instruction's upper three bits, lower two bits or full seven bits
package seq_jump_pkg;
	localparam int ADDR_W = 16; // address and data width
	localparam int INSTR_W = 7; // instruction width
	localparam int STACK_DEPTH = 64; // internal ram words
	localparam int SUB_DEPTH = 16; // subroutine stack words
	localparam int NUM_CNT = 4; // event counters
	localparam logic [6:0] OP_REPEAT_FLAG_LOW = 7'h35; // 011 0101
	localparam logic [6:0] OP_REPEAT_FLAG_HIGH = 7'h15; // 001 0101
	localparam logic [2:0] GRP_REG_STACK = 3'h6; // 110 cc ii
	localparam logic [2:0] GRP_SKIP_RET = 3'h5; // 101 cc xx
	localparam logic [2:0] GRP_CALL = 3'h7; // 111 cc xx
	localparam logic [1:0] LOW_SKIP = 2'h1; // 101 cc 01
	localparam logic [1:0] LOW_RETURN = 2'h3; // 101 cc 11
	localparam logic [1:0] LOW_CALL_ABS = 2'h0; // 111 cc 00
	localparam logic [1:0] LOW_CALL_REL = 2'h2; // 111 cc 10
	localparam logic [1:0] COND_ALWAYS = 2'h0;
	localparam logic [1:0] COND_FLAG_LOW = 2'h1;
	localparam logic [1:0] COND_FLAG_HIGH = 2'h2;
	localparam logic [1:0] COND_SIGN = 2'h3;
	localparam logic [1:0] WIDTH_16 = 2'h0; // status_word[5:4] codes
	localparam logic [1:0] WIDTH_12 = 2'h1;
	localparam logic [1:0] WIDTH_8 = 2'h2;
	localparam int SIGN_BIT_POS = 1; // status_word sign bit
	localparam int WIDTH_LSB_POS = 4; // status_word width field
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
endpackage

// ===== hw/cond_jump_next_address.sv
// Purpose: next-address selection for conditional jumps, repeats, skips, calls, returns
// Assumes: inputs synchronous to mclk_in; the store returns instr_in for addr_out
// Notes: stack pointers, ram and counters are loaded through simple write ports
`timescale 1ns/10ps
`default_nettype none

module cond_jump_next_address
	import seq_jump_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int RAM_WORDS = STACK_DEPTH,
	parameter int SS_WORDS = SUB_DEPTH
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [INSTR_W-1:0] instr_in, // instruction from control store
	input wire logic [AW-1:0] data_in, // data port value
	input wire logic flag_in, // condition flag
	input wire logic use_local_in, // 1 selects local_stack_pointer
	input wire logic ptr_wr_in, // load selected pointer
	input wire logic [5:0] ptr_data_in,
	input wire logic ram_wr_in, // write internal ram word
	input wire logic [5:0] ram_addr_in,
	input wire logic cnt_wr_in, // load a counter
	input wire logic [1:0] cnt_idx_in,
	input wire logic [AW-1:0] cnt_data_in,
	input wire logic width_wr_in, // load offset width field
	input wire logic [1:0] width_in,
	output logic [AW-1:0] addr_out, // next microcode address
	output logic [AW-1:0] status_out, // status_word
	output logic [AW-1:0] cnt0_out // counter 0 for observation
);
	logic [AW-1:0] pc_q; // address of the executing instruction
	logic [AW-1:0] addr_d;
	logic [AW-1:0] status_q;
	logic [5:0] gsp_q; // global_stack_pointer
	logic [5:0] lsp_q; // local_stack_pointer
	logic [AW-1:0] ram_q [RAM_WORDS]; // register stack ram
	logic [AW-1:0] cnt_q [NUM_CNT]; // event counters
	logic [AW-1:0] ss_q [SS_WORDS]; // subroutine stack
	logic [$clog2(SS_WORDS)-1:0] ss_ptr_q; // next free slot
	logic [2:0] grp;
	logic [1:0] condition_field;
	logic [1:0] index_field;
	logic cond_true;
	logic cnt_sign;
	logic dec_cnt, do_push, do_pop, capture_sign;
	logic [AW-1:0] pc_inc;
	logic [5:0] ram_ptr;
	localparam int SSP_W = $clog2(SS_WORDS); // subroutine pointer width, wraps silently

	// sign-extend the data offset to the selected width
	function automatic logic [AW-1:0] sext_offset(input logic [AW-1:0] d, input logic [1:0] w);
		logic [AW-1:0] r;
		r = d;
		unique case (w)
			WIDTH_12: r = {{(AW-12){d[11]}}, d[11:0]};
			WIDTH_8: r = {{(AW-8){d[7]}}, d[7:0]};
			default: r = d; // 16-bit and reserved code
		endcase
		return r;
	endfunction

	assign grp = instr_in[6:4];
	assign condition_field = instr_in[3:2];
	assign index_field = instr_in[1:0];
	assign pc_inc = pc_q + AW'(1);
	assign cnt_sign = cnt_q[index_field][AW-1];
	assign ram_ptr = (use_local_in ? lsp_q : gsp_q) + {4'h0, index_field};

	// condition decode; sign comes from status bit one here
	always_comb begin
		unique case (condition_field)
			COND_ALWAYS: cond_true = 1'b1;
			COND_FLAG_LOW: cond_true = !flag_in;
			COND_FLAG_HIGH: cond_true = flag_in;
			default: cond_true = status_q[SIGN_BIT_POS];
		endcase
	end

	// next-address mux; anything not decoded here just advances
	always_comb begin
		addr_d = pc_inc;
		dec_cnt = 1'b0;
		do_push = 1'b0;
		do_pop = 1'b0;
		capture_sign = 1'b0;
		if (instr_in == OP_REPEAT_FLAG_LOW) begin
			if (!flag_in) addr_d = pc_q;
		end else if (instr_in == OP_REPEAT_FLAG_HIGH) begin
			if (flag_in) addr_d = pc_q;
		end else if (grp == GRP_REG_STACK) begin
			if (condition_field == COND_SIGN) begin
				dec_cnt = 1'b1;
				capture_sign = 1'b1;
				if (cnt_sign) addr_d = ram_q[ram_ptr];
			end else if (cond_true) begin
				addr_d = ram_q[ram_ptr];
			end
		end else if (grp == GRP_SKIP_RET && cond_true) begin
			if (index_field == LOW_SKIP) addr_d = pc_q + AW'(2);
			if (index_field == LOW_RETURN) begin
				addr_d = ss_q[ss_ptr_q - SSP_W'(1)];
				do_pop = 1'b1;
			end
		end else if (grp == GRP_CALL && cond_true) begin
			if (index_field == LOW_CALL_ABS) begin
				addr_d = data_in;
				do_push = 1'b1;
			end
			if (index_field == LOW_CALL_REL) begin
				addr_d = pc_inc + sext_offset(data_in, status_q[WIDTH_LSB_POS+:2]);
				do_push = 1'b1;
			end
		end
	end

	// program counter and address output register
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pc_q <= ADDR_RESET;
			addr_out <= ADDR_RESET;
		end else begin
			pc_q <= addr_d;
			addr_out <= addr_d;
		end
	end

	// status word: width field and captured counter sign
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			status_q <= STATUS_RESET;
			status_out <= STATUS_RESET;
		end else begin
			if (capture_sign) status_q[SIGN_BIT_POS] <= cnt_sign;
			if (width_wr_in) status_q[WIDTH_LSB_POS+:2] <= width_in;
			status_out <= status_q;
		end
	end

	// stack pointers
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			gsp_q <= 6'h00;
			lsp_q <= 6'h00;
		end else if (ptr_wr_in) begin
			if (use_local_in) lsp_q <= ptr_data_in;
			else gsp_q <= ptr_data_in;
		end
	end

	// register stack ram; contents not reset
	always_ff @(posedge mclk_in) begin
		if (ram_wr_in) ram_q[ram_addr_in] <= data_in;
	end

	// counters; decrement wins over a load on the same index
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_CNT; i++) cnt_q[i] <= '0;
			cnt0_out <= '0;
		end else begin
			if (cnt_wr_in) cnt_q[cnt_idx_in] <= cnt_data_in;
			if (dec_cnt) cnt_q[index_field] <= cnt_q[index_field] - AW'(1);
			cnt0_out <= cnt_q[0];
		end
	end

	// subroutine stack push and pop
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ss_ptr_q <= '0;
		end else if (do_push) begin
			ss_q[ss_ptr_q] <= pc_inc;
			ss_ptr_q <= ss_ptr_q + SSP_W'(1);
		end else if (do_pop) begin
			ss_ptr_q <= ss_ptr_q - SSP_W'(1);
		end
	end

	// assertions
	repeat_low_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		instr_in == OP_REPEAT_FLAG_LOW && !flag_in |=> addr_out == $past(pc_q))
		else $error("repeat on flag low did not hold pc");
	repeat_high_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		instr_in == OP_REPEAT_FLAG_HIGH && flag_in |=> addr_out == $past(pc_q))
		else $error("repeat on flag high did not hold pc");
	skip_two_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		grp == GRP_SKIP_RET && index_field == LOW_SKIP && cond_true
		|=> addr_out == $past(pc_q) + 16'h0002)
		else $error("skip did not give pc plus two");
	false_cond_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(grp == GRP_CALL || grp == GRP_SKIP_RET) && !cond_true
		|=> addr_out == $past(pc_q) + 16'h0001 && $stable(ss_ptr_q))
		else $error("false condition did not advance by one");
	call_push_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		grp == GRP_CALL && index_field == LOW_CALL_ABS && cond_true
		|=> addr_out == $past(data_in) && ss_ptr_q == $past(ss_ptr_q) + SSP_W'(1))
		else $error("absolute call wrong");
	call_ret_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		grp == GRP_CALL && index_field == LOW_CALL_ABS && cond_true ##1
		grp == GRP_SKIP_RET && index_field == LOW_RETURN && cond_true
		|=> addr_out == $past(pc_q, 2) + 16'h0001)
		else $error("return did not restore call address");
	sign_copy_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		grp == GRP_REG_STACK && condition_field == COND_SIGN
		|=> status_q[SIGN_BIT_POS] == $past(cnt_sign))
		else $error("counter sign not captured");
	cnt_dec_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		grp == GRP_REG_STACK && condition_field == COND_SIGN && !cnt_wr_in
		|=> cnt_q[$past(index_field)] == $past(cnt_q[index_field]) - AW'(1))
		else $error("counter not decremented");
	rel_call_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		grp == GRP_CALL && index_field == LOW_CALL_REL && cond_true
		&& status_q[WIDTH_LSB_POS+:2] == WIDTH_8
		|=> addr_out == $past(pc_q) + 16'h0001 + {{8{$past(data_in[7])}}, $past(data_in[7:0])})
		else $error("relative call offset wrong");
	cover_repeat_c: cover property (@(posedge mclk_in) instr_in == OP_REPEAT_FLAG_LOW && !flag_in);
	cover_call_c: cover property (@(posedge mclk_in) do_push ##[1:4] do_pop);
	cover_sign_c: cover property (@(posedge mclk_in) dec_cnt && cnt_sign);
endmodule
`default_nettype wire

// ===== dv/control_store_model.sv
// Purpose: control store and data bus on the far side of the sequencer
// Assumes: one instruction and one data word for each address
// Notes: a data word never loaded reads as the inverted address, not a held value
`timescale 1ns/10ps
`default_nettype none
module control_store_model
	import seq_jump_pkg::*;
(
	input wire logic [ADDR_W-1:0] addr_in, // address from the sequencer
	output logic [INSTR_W-1:0] instr_out, // instruction at addr_in
	output logic [ADDR_W-1:0] data_out // data port word at addr_in
);
	logic [INSTR_W-1:0] code [0:65535]; // instruction words
	logic [ADDR_W-1:0] word [0:65535]; // data words
	// no delay: both are sampled at the next edge
	assign instr_out = code[addr_in];
	assign data_out = word[addr_in];
	// blank store: plain increments, data that is never a stale target
	task automatic clear;
		for (int i = 0; i < 65536; i++) begin
			code[i] = 7'h00;
			word[i] = ~16'(i);
		end
	endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench for the next-address block
// Assumes: the store model answers each address at once
// Notes: the stack scenario reads through the local pointer; the global one holds a decoy
`timescale 1ns/10ps
`default_nettype none
module testbench
	import seq_jump_pkg::*;
;
	logic mclk_in = 0, rst_n_in = 0, flag_in = 0, use_local_in = 0; // clock, reset, flag, pointer
	logic ptr_wr_in = 0, ram_wr_in = 0, cnt_wr_in = 0, width_wr_in = 0; // load pulses
	logic [INSTR_W-1:0] instr_in;
	logic [15:0] data_in, addr_out, status_out, cnt0_out, cnt_data_in = 0;
	logic [5:0] ptr_data_in = 0, ram_addr_in = 0;
	logic [1:0] cnt_idx_in = 0, width_in = 0;
	int n_fail = 0, num_checks = 0;
	// 125 MHz clock
	always #4 mclk_in = ~mclk_in;
	cond_jump_next_address cond_jump_next_address_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.instr_in(instr_in), .data_in(data_in), .flag_in(flag_in), .use_local_in(use_local_in),
		.ptr_wr_in(ptr_wr_in), .ptr_data_in(ptr_data_in), .ram_wr_in(ram_wr_in),
		.ram_addr_in(ram_addr_in), .cnt_wr_in(cnt_wr_in), .cnt_idx_in(cnt_idx_in),
		.cnt_data_in(cnt_data_in), .width_wr_in(width_wr_in), .width_in(width_in),
		.addr_out(addr_out), .status_out(status_out), .cnt0_out(cnt0_out));
	control_store_model control_store_model_i (.addr_in(addr_out), .instr_out(instr_in),
		.data_out(data_in));
	task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task put(input logic [15:0] a, input logic [6:0] op, input logic [15:0] d);
		control_store_model_i.code[a] = op;
		control_store_model_i.word[a] = d;
	endtask
	// reset for 2 edges; address 0 repeats while the flag is low
	task boot;
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		flag_in <= 1'b0;
		use_local_in <= 1'b0;
		// store is rewritten off the edge so the design never races it
		@(negedge mclk_in);
		control_store_model_i.clear();
		put(16'h0000, OP_REPEAT_FLAG_LOW, 16'h0000);
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(negedge mclk_in);
		cmp("reset addr", 16'h0000, addr_out);
	endtask
	// one load pulse (k: ptr, ram, cnt, width) while the pc is parked at 0
	task ld(input logic [3:0] k, input logic [5:0] a, input logic [15:0] v);
		@(posedge mclk_in);
		ptr_wr_in <= k[0];
		ram_wr_in <= k[1];
		cnt_wr_in <= k[2];
		width_wr_in <= k[3];
		ptr_data_in <= a;
		ram_addr_in <= a;
		cnt_idx_in <= a[1:0];
		width_in <= a[1:0];
		cnt_data_in <= v;
		@(negedge mclk_in);
		put(16'h0000, OP_REPEAT_FLAG_LOW, v); // ram data comes from the data port
		cmp("parked addr", 16'h0000, addr_out);
	endtask
	// f is the flag seen by the instruction at exp
	task step(input logic f, input logic [15:0] exp);
		@(posedge mclk_in);
		flag_in <= f;
		ptr_wr_in <= 1'b0;
		ram_wr_in <= 1'b0;
		cnt_wr_in <= 1'b0;
		width_wr_in <= 1'b0;
		@(negedge mclk_in);
		cmp("next addr", exp, addr_out);
	endtask
	task s_repeat;
		boot();
		put(16'h0001, OP_REPEAT_FLAG_HIGH, 16'h0000);
		step(1'b1, 16'h0000);
		step(1'b1, 16'h0001);
		step(1'b0, 16'h0001);
		step(1'b0, 16'h0002);
	endtask
	task s_skip;
		boot();
		put(16'h0001, 7'h51, 16'h0000);
		put(16'h0003, 7'h55, 16'h0000);
		put(16'h0005, 7'h59, 16'h0000);
		put(16'h0006, 7'h5d, 16'h0000);
		step(1'b1, 16'h0000);
		step(1'b0, 16'h0001);
		step(1'b0, 16'h0003);
		step(1'b0, 16'h0005);
		step(1'b0, 16'h0006);
		step(1'b0, 16'h0007);
	endtask
	task s_stack;
		boot();
		ld(4'h2, 6'h22, 16'h0abc);
		ld(4'h2, 6'h20, 16'h0100);
		ld(4'h1, 6'h10, 16'h0000);
		@(posedge mclk_in);
		use_local_in <= 1'b1; // a wrong pointer choice would read unwritten ram
		ld(4'h1, 6'h20, 16'h0000);
		ld(4'h4, 6'h00, 16'h0000);
		put(16'h0001, 7'h62, 16'h0000);
		put(16'h0abc, 7'h6c, 16'h0000);
		put(16'h0abd, 7'h6c, 16'h0000);
		put(16'h0100, 7'h5d, 16'h0000);
		step(1'b1, 16'h0000);
		step(1'b0, 16'h0001);
		step(1'b0, 16'h0abc);
		step(1'b0, 16'h0abd);
		step(1'b0, 16'h0100);
		step(1'b0, 16'h0102);
		cmp("sign bit", 16'h0002, status_out & 16'h0002);
		cmp("counter 0", 16'hfffe, cnt0_out);
	endtask
	task s_call;
		boot();
		put(16'h0001, 7'h70, 16'h0040);
		put(16'h0040, 7'h7a, 16'hfff0);
		put(16'h0031, 7'h57, 16'h0000);
		put(16'h0032, 7'h53, 16'h0000);
		put(16'h0041, 7'h76, 16'h0000);
		put(16'h0042, 7'h53, 16'h0000);
		put(16'h0002, 7'h70, 16'h0050);
		put(16'h0050, 7'h53, 16'h0000);
		step(1'b1, 16'h0000);
		step(1'b0, 16'h0001);
		step(1'b1, 16'h0040);
		step(1'b1, 16'h0031);
		step(1'b0, 16'h0032);
		step(1'b1, 16'h0041);
		step(1'b0, 16'h0042);
		step(1'b0, 16'h0002);
		step(1'b0, 16'h0050);
		step(1'b0, 16'h0003);
		step(1'b0, 16'h0004);
	endtask
	task s_width;
		logic [15:0] d;
		logic [15:0] off;
		d = 16'h08f0;
		// code 3 is the reserved width and behaves as 16 bits
		for (int w = 0; w < 4; w++) begin
			boot();
			ld(4'h8, 6'(w), 16'h0000);
			put(16'h0001, 7'h72, d);
			off = (w == 1) ? {{4{d[11]}}, d[11:0]} : (w == 2) ? {{8{d[7]}}, d[7:0]} : d;
			step(1'b1, 16'h0000);
			step(1'b0, 16'h0001);
			cmp("width field", 16'(w) << WIDTH_LSB_POS, status_out & 16'h0030);
			step(1'b0, 16'h0002 + off);
			step(1'b0, 16'h0003 + off);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		s_repeat();
		s_skip();
		s_stack();
		s_call();
		s_width();
		conclude();
	end
	// watchdog: the tests need fewer than a hundred cycles
	initial begin
		repeat (3000) @(posedge mclk_in);
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
